// ===== hw/mpa_pkg.sv
// Constants, types and helpers of the measurement period averager
package mpa_pkg;
  localparam int NE = 2;
  localparam int NCH = 2 * NE;
  localparam int SW = 16;
  localparam int AW = 48;
  localparam int CW = 32;
  localparam int EW = 64;
  localparam int FRB = 8;
  localparam int YW = SW + FRB;
  localparam int EXP_STAGES = 3;
  localparam int EXP_SHIFT = 4;
  localparam int CF_FRAC = 8;
  localparam int RATE_W = 4;
  localparam int SRC_W = 3;
  localparam int HW = 14;
  // Harmonic window length, 9000 samples
  localparam logic [HW-1:0] HARM_WIN = 14'h2328;
  localparam logic [RATE_W-1:0] RATE_50MS = 4'h0;
  localparam logic [RATE_W-1:0] RATE_100MS = 4'h1;
  localparam logic [RATE_W-1:0] RATE_250MS = 4'h2;
  localparam logic [RATE_W-1:0] RATE_500MS = 4'h3;
  localparam logic [RATE_W-1:0] RATE_1S = 4'h4;
  localparam logic [RATE_W-1:0] RATE_2S = 4'h5;
  localparam logic [RATE_W-1:0] RATE_5S = 4'h6;
  localparam logic [RATE_W-1:0] RATE_10S = 4'h7;
  localparam logic [RATE_W-1:0] RATE_20S = 4'h8;
  // Codes at or above this select no sync source
  localparam logic [SRC_W-1:0] SRC_NONE = 3'h4;
  localparam logic [1:0] XN_FULL = 2'h2;
  localparam logic [CW-1:0] CNT_ZERO = 32'h0;
  localparam logic signed [SW-1:0] PK_MIN = 16'sh8000;
  localparam logic signed [SW-1:0] PK_MAX = 16'sh7fff;
  localparam logic [SW-1:0] CF_SAT = 16'hffff;

  typedef enum logic {
    MPA_RUN = 1'b0,
    MPA_FIN = 1'b1
  } mpa_state_t;

  typedef struct packed {
    logic signed [SW-1:0] voltage_mean;
    logic signed [SW-1:0] current_mean;
    logic signed [SW-1:0] voltage_max_peak;
    logic signed [SW-1:0] current_max_peak;
    logic signed [SW-1:0] current_min_peak;
    logic [SW-1:0] voltage_crest_factor;
    logic [SW-1:0] current_crest_factor;
    logic signed [EW-1:0] energy;
    logic signed [AW-1:0] charge;
  } mpa_elem_t;

  typedef struct packed {
    logic exp_mode;
    mpa_elem_t [NE-1:0] elem;
  } mpa_result_t;

  function automatic logic is_exp_rate(input logic [RATE_W-1:0] r);
    return (r == RATE_250MS) || (r == RATE_500MS) || (r == RATE_1S) || (r == RATE_2S);
  endfunction

  function automatic logic signed [SW-1:0] avg(input logic signed [AW-1:0] s, input logic [CW-1:0] n);
    logic signed [AW-1:0] q;
    q = '0;
    if (n != CNT_ZERO) begin
      q = s / $signed({16'h0, n});
    end
    return q[SW-1:0];
  endfunction

  function automatic logic [SW-1:0] crest(input logic [SW-1:0] pk, input logic [CW-1:0] n,
                                          input logic [AW-1:0] asum);
    logic [EW-1:0] num;
    logic [EW-1:0] q;
    num = (EW'(pk) << CF_FRAC) * EW'(n);
    q = '0;
    if (asum != '0) begin
      q = num / EW'(asum);
    end
    return (q > EW'(CF_SAT)) ? CF_SAT : q[SW-1:0];
  endfunction

  function automatic logic [SW-1:0] mag(input logic signed [SW-1:0] x);
    return x[SW-1] ? SW'(-x) : x;
  endfunction
endpackage

// ===== hw/mpa_buf_if.sv
// Result handshake between the averaging engine and its output buffer
`timescale 1ns/1ps
interface mpa_buf_if;
  logic in_valid;
  logic in_ready;
  mpa_pkg::mpa_result_t in_data;
  logic out_valid;
  logic out_ready;
  mpa_pkg::mpa_result_t out_data;
  modport prod (output in_valid, output in_data, input in_ready);
  modport store (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
  modport cons (input out_valid, input out_data, output out_ready);
endinterface

// ===== hw/mpa_skid_buf.sv
// Two-entry result buffer with registered outputs
`timescale 1ns/1ps
module mpa_skid_buf (
  input wire logic clk,
  input wire logic rstn,
  mpa_buf_if.store bif
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic vld_reg;
  mpa_pkg::mpa_result_t head_reg;
  mpa_pkg::mpa_result_t spare_reg;
  logic push;
  logic pop;

  assign bif.in_ready = (cnt_reg != 2'h2);
  assign bif.out_valid = vld_reg;
  assign bif.out_data = head_reg;
  assign push = bif.in_valid && bif.in_ready;
  assign pop = vld_reg && bif.out_ready;
  assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 2'h0;
      vld_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      vld_reg <= (cnt_next != 2'h0);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      head_reg <= '0;
      spare_reg <= '0;
    end else begin
      if (push && (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop))) begin
        head_reg <= bif.in_data;
      end else if (pop && cnt_reg == 2'h2) begin
        head_reg <= spare_reg;
      end
      if (push && cnt_reg == 2'h1 && !pop) begin
        spare_reg <= bif.in_data;
      end
    end
  end
endmodule

// ===== hw/mpa_averager.sv
// Measurement period averaging engine, one result per data update interval
`timescale 1ns/1ps
// Notes on behaviour
// R01: Rates 50 ms, 100 ms, 5 s, 10 s, 20 s use sync-period averaging.
// R02: Rates 250 ms to 2 s use exponential filtering over the whole interval.
// R03: Each filter stage adds (sample minus output) over a constant; stages cascade.
// R04: Exponential result is the last cascade output of the interval.
// R05: Sync mode averages over whole periods of the chosen sync source.
// R06: Energy and charge always use the whole interval.
// R07: Peaks and crest factors always use the whole interval.
// R08: Harmonic window spans 9000 harmonic samples from interval start.
// R09: Exponential period is the same for all elements, ignoring sync sources.
// R10: Controller must choose a sync source per element for sync mode.
// R11: Each element may pick any element's voltage or current as sync source.
// R12: Span runs first to last crossing; the longer of rising or falling wins.
// R13: Under two same-slope crossings, the whole interval is averaged.
// R14: All results are latched at interval end and held together.
module mpa_averager (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [mpa_pkg::RATE_W-1:0] rate_sel,
  input wire logic [mpa_pkg::NE-1:0][mpa_pkg::SRC_W-1:0] sync_sel,
  input wire logic samp_valid,
  output logic samp_ready,
  input wire logic samp_last,
  input wire logic signed [mpa_pkg::NE-1:0][mpa_pkg::SW-1:0] samp_volt,
  input wire logic signed [mpa_pkg::NE-1:0][mpa_pkg::SW-1:0] samp_curr,
  input wire logic harm_tick,
  output logic harm_window,
  output logic exp_mode,
  output logic res_valid,
  input wire logic res_ready,
  output mpa_pkg::mpa_result_t res_data
);
  localparam int NE = mpa_pkg::NE;
  localparam int NCH = mpa_pkg::NCH;
  localparam int SW = mpa_pkg::SW;
  localparam int AW = mpa_pkg::AW;
  localparam int CW = mpa_pkg::CW;
  localparam int YW = mpa_pkg::YW;
  localparam int NST = mpa_pkg::EXP_STAGES;

  mpa_buf_if bif ();
  mpa_pkg::mpa_state_t state_reg;
  logic ready_reg;
  logic exp_reg;
  logic [CW-1:0] cnt_reg;
  logic [mpa_pkg::HW-1:0] harm_cnt_reg;
  logic harm_win_reg;
  logic take;
  logic push;
  logic fin_next;
  logic signed [SW-1:0] x [NCH];
  logic psgn_reg [NCH];
  logic rise [NCH];
  logic fall [NCH];
  logic signed [AW-1:0] sum_reg [NCH];
  logic [AW-1:0] asum_reg [NCH];
  logic signed [SW-1:0] max_reg [NCH];
  logic signed [SW-1:0] min_reg [NCH];
  logic [SW-1:0] pk_reg [NCH];
  logic signed [AW-1:0] pre_first_reg [NCH][2];
  logic signed [AW-1:0] pre_last_reg [NCH][2];
  logic signed [YW-1:0] y_reg [NCH][NST];
  logic signed [mpa_pkg::EW-1:0] energy_reg [NE];
  logic [CW-1:0] first_reg [NE][2];
  logic [CW-1:0] last_reg [NE][2];
  logic [1:0] xn_reg [NE][2];
  mpa_pkg::mpa_result_t res_c;

  mpa_skid_buf u_buf (
    .clk(clk),
    .rstn(rstn),
    .bif(bif.store)
  );

  assign take = samp_valid && ready_reg;
  assign push = (state_reg == mpa_pkg::MPA_FIN) && bif.in_ready;
  assign fin_next = (take && samp_last) || ((state_reg == mpa_pkg::MPA_FIN) && !push);
  assign bif.in_valid = (state_reg == mpa_pkg::MPA_FIN);
  assign bif.in_data = res_c;
  assign bif.out_ready = res_ready;
  assign res_valid = bif.out_valid;
  assign res_data = bif.out_data;
  assign samp_ready = ready_reg;
  assign harm_window = harm_win_reg;
  assign exp_mode = exp_reg;

  // Interval sequencing; a full buffer stalls the sample source
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= mpa_pkg::MPA_RUN;
      ready_reg <= 1'b0;
      cnt_reg <= mpa_pkg::CNT_ZERO;
    end else begin
      state_reg <= fin_next ? mpa_pkg::MPA_FIN : mpa_pkg::MPA_RUN; // [R14]
      ready_reg <= !fin_next;
      if (push) begin
        cnt_reg <= mpa_pkg::CNT_ZERO;
      end else if (take) begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end
  end

  // Method chosen once per interval, at the edge that takes its first sample
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exp_reg <= 1'b0;
    end else if (state_reg == mpa_pkg::MPA_RUN && cnt_reg == mpa_pkg::CNT_ZERO) begin
      exp_reg <= mpa_pkg::is_exp_rate(rate_sel); // [R01] [R02]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      harm_cnt_reg <= '0;
      harm_win_reg <= 1'b1;
    end else if (push) begin
      harm_cnt_reg <= '0;
      harm_win_reg <= 1'b1;
    end else if (harm_tick && harm_cnt_reg < mpa_pkg::HARM_WIN) begin
      harm_cnt_reg <= harm_cnt_reg + 14'h1;
      harm_win_reg <= (harm_cnt_reg + 14'h1) < mpa_pkg::HARM_WIN; // [R08]
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    if (c % 2 == 0) begin : g_v
      assign x[c] = samp_volt[c/2];
    end else begin : g_i
      assign x[c] = samp_curr[c/2];
    end
    assign rise[c] = take && psgn_reg[c] && !x[c][SW-1];
    assign fall[c] = take && !psgn_reg[c] && x[c][SW-1];

    // Whole-interval sums and extremes
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        psgn_reg[c] <= 1'b0;
        sum_reg[c] <= '0;
        asum_reg[c] <= '0;
        max_reg[c] <= mpa_pkg::PK_MIN;
        min_reg[c] <= mpa_pkg::PK_MAX;
        pk_reg[c] <= '0;
      end else if (push) begin
        sum_reg[c] <= '0;
        asum_reg[c] <= '0;
        max_reg[c] <= mpa_pkg::PK_MIN;
        min_reg[c] <= mpa_pkg::PK_MAX;
        pk_reg[c] <= '0;
      end else if (take) begin
        psgn_reg[c] <= x[c][SW-1];
        sum_reg[c] <= sum_reg[c] + AW'(x[c]); // [R05] [R06]
        asum_reg[c] <= asum_reg[c] + AW'(mpa_pkg::mag(x[c]));
        if (x[c] > max_reg[c]) max_reg[c] <= x[c]; // [R07]
        if (x[c] < min_reg[c]) min_reg[c] <= x[c]; // [R07]
        if (mpa_pkg::mag(x[c]) > pk_reg[c]) pk_reg[c] <= mpa_pkg::mag(x[c]);
      end
    end

    // Cascaded exponential stages, common to every element
    for (genvar s = 0; s < NST; s++) begin : g_st
      logic signed [YW:0] d;
      if (s == 0) begin : g_in
        assign d = {x[c][SW-1], x[c], 8'h00} - {y_reg[c][s][YW-1], y_reg[c][s]};
      end else begin : g_cas
        assign d = {y_reg[c][s-1][YW-1], y_reg[c][s-1]} - {y_reg[c][s][YW-1], y_reg[c][s]};
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          y_reg[c][s] <= '0;
        end else if (take) begin
          y_reg[c][s] <= y_reg[c][s] + YW'(d >>> mpa_pkg::EXP_SHIFT); // [R03] [R09]
        end
      end
    end
  end

  for (genvar e = 0; e < NE; e++) begin : g_el
    logic src_ok;
    logic [1:0] cr;
    logic [mpa_pkg::SRC_W-1:0] sel;
    assign sel = sync_sel[e];
    assign src_ok = sel < mpa_pkg::SRC_NONE; // [R10]
    assign cr[0] = src_ok && rise[sel[1:0]]; // [R11]
    assign cr[1] = src_ok && fall[sel[1:0]];

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        energy_reg[e] <= '0;
      end else if (push) begin
        energy_reg[e] <= '0;
      end else if (take) begin
        energy_reg[e] <= energy_reg[e] + mpa_pkg::EW'(x[2*e] * x[2*e+1]); // [R06]
      end
    end

    // Crossing positions and the running sums at them
    for (genvar k = 0; k < 2; k++) begin : g_sl
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          xn_reg[e][k] <= 2'h0;
          first_reg[e][k] <= mpa_pkg::CNT_ZERO;
          last_reg[e][k] <= mpa_pkg::CNT_ZERO;
          pre_first_reg[2*e][k] <= '0;
          pre_first_reg[2*e+1][k] <= '0;
          pre_last_reg[2*e][k] <= '0;
          pre_last_reg[2*e+1][k] <= '0;
        end else if (push) begin
          xn_reg[e][k] <= 2'h0;
        end else if (cr[k]) begin
          if (xn_reg[e][k] == 2'h0) begin
            first_reg[e][k] <= cnt_reg; // [R12]
            pre_first_reg[2*e][k] <= sum_reg[2*e];
            pre_first_reg[2*e+1][k] <= sum_reg[2*e+1];
          end
          last_reg[e][k] <= cnt_reg; // [R12]
          pre_last_reg[2*e][k] <= sum_reg[2*e];
          pre_last_reg[2*e+1][k] <= sum_reg[2*e+1];
          if (xn_reg[e][k] != mpa_pkg::XN_FULL) xn_reg[e][k] <= xn_reg[e][k] + 2'h1;
        end
      end
    end
  end

  // Result word assembled while the interval is closing
  always_comb begin
    logic ok0;
    logic ok1;
    logic pick;
    logic [CW-1:0] span;
    logic signed [SW-1:0] m [2];
    ok0 = 1'b0;
    ok1 = 1'b0;
    pick = 1'b0;
    span = '0;
    m[0] = '0;
    m[1] = '0;
    res_c = '0;
    res_c.exp_mode = exp_reg;
    for (int e = 0; e < NE; e++) begin
      ok0 = xn_reg[e][0] == mpa_pkg::XN_FULL;
      ok1 = xn_reg[e][1] == mpa_pkg::XN_FULL;
      pick = ok1 && (!ok0 || (last_reg[e][1] - first_reg[e][1]) > (last_reg[e][0] - first_reg[e][0])); // [R12]
      span = last_reg[e][pick] - first_reg[e][pick];
      for (int j = 0; j < 2; j++) begin
        if (exp_reg) begin
          m[j] = y_reg[2*e+j][NST-1][YW-1 -: SW]; // [R04]
        end else if (ok0 || ok1) begin
          m[j] = mpa_pkg::avg(pre_last_reg[2*e+j][pick] - pre_first_reg[2*e+j][pick], span); // [R05]
        end else begin
          m[j] = mpa_pkg::avg(sum_reg[2*e+j], cnt_reg); // [R13]
        end
      end
      res_c.elem[e].voltage_mean = m[0];
      res_c.elem[e].current_mean = m[1];
      res_c.elem[e].voltage_max_peak = max_reg[2*e]; // [R07]
      res_c.elem[e].current_max_peak = max_reg[2*e+1];
      res_c.elem[e].current_min_peak = min_reg[2*e+1];
      res_c.elem[e].voltage_crest_factor = mpa_pkg::crest(pk_reg[2*e], cnt_reg, asum_reg[2*e]); // [R07]
      res_c.elem[e].current_crest_factor = mpa_pkg::crest(pk_reg[2*e+1], cnt_reg, asum_reg[2*e+1]);
      res_c.elem[e].energy = energy_reg[e]; // [R06]
      res_c.elem[e].charge = sum_reg[2*e+1];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence last_taken;
    take && samp_last;
  endsequence
  sequence closing;
    (state_reg == mpa_pkg::MPA_FIN) && !samp_ready;
  endsequence

  interval_close_a: assert property (last_taken |=> closing) else $error("interval did not close"); // [R14]
  result_hold_a: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
    else $error("result changed before acceptance"); // [R14]
  method_pick_a: assert property ((state_reg == mpa_pkg::MPA_RUN && cnt_reg == mpa_pkg::CNT_ZERO)
    |=> exp_reg == mpa_pkg::is_exp_rate($past(rate_sel))) else $error("wrong averaging method"); // [R01]
  exp_result_a: assert property (push && exp_reg |-> res_c.elem[0].voltage_mean == y_reg[0][NST-1][YW-1 -: SW])
    else $error("exponential result not final stage"); // [R04]
  harm_window_a: assert property (harm_cnt_reg >= mpa_pkg::HARM_WIN |-> !harm_window) else $error("window open late"); // [R08]
  harm_open_a: assert property (push |=> harm_window && harm_cnt_reg == '0) else $error("window not reopened"); // [R08]
  peak_whole_a: assert property (take && !push |=> max_reg[0] >= $past(x[0]) && min_reg[0] <= $past(x[0]))
    else $error("peak missed a sample"); // [R07]
  energy_whole_a: assert property (push |-> res_c.elem[0].energy == energy_reg[0] && res_c.elem[0].charge == sum_reg[1])
    else $error("energy not whole interval"); // [R06]
  fallback_a: assert property (push && !exp_reg && xn_reg[0][0] != mpa_pkg::XN_FULL && xn_reg[0][1] != mpa_pkg::XN_FULL
    |-> res_c.elem[0].voltage_mean == mpa_pkg::avg(sum_reg[0], cnt_reg)) else $error("fallback not whole interval"); // [R13]
  exp_step_a: assert property (take ##1 !take |=> $stable(y_reg[0][0])) else $error("filter moved without sample"); // [R03]
endmodule

// ===== tb/mpa_src_model.sv
// Acquisition channel model: offers sample words and harmonic ticks
`timescale 1ns/1ps
module mpa_src_model (
  input wire logic clk,
  input wire logic samp_ready,
  output logic samp_valid,
  output logic samp_last,
  output logic signed [mpa_pkg::NE-1:0][mpa_pkg::SW-1:0] samp_volt,
  output logic signed [mpa_pkg::NE-1:0][mpa_pkg::SW-1:0] samp_curr,
  output logic harm_tick,
  output logic hung
);
  initial begin
    samp_valid = 1'b0;
    samp_last = 1'b0;
    samp_volt = '0;
    samp_curr = '0;
    harm_tick = 1'b0;
    hung = 1'b0;
  end

  // Called at a rising edge; word held until taken
  task automatic put(input logic signed [mpa_pkg::SW-1:0] v0, i0, v1, i1, input logic last, input int stall);
    int n;
    // A stall drops valid so the held word is not taken twice
    if (stall > 0) begin
      #1;
      samp_valid = 1'b0;
      repeat (stall) @(posedge clk);
    end
    #1;
    samp_valid = 1'b1;
    samp_last = last;
    samp_volt = {v1, v0};
    samp_curr = {i1, i0};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!samp_ready && n < 200);
    if (!samp_ready) hung = 1'b1;
  endtask

  // Released lines show the inverse of the last word
  task automatic idle();
    #1;
    samp_valid = 1'b0;
    samp_last = 1'b0;
    samp_volt = ~samp_volt;
    samp_curr = ~samp_curr;
  endtask

  task automatic harm(input int n);
    repeat (n) begin
      @(posedge clk);
      #1 harm_tick = 1'b1;
      @(posedge clk);
      #1 harm_tick = 1'b0;
    end
  endtask
endmodule

// ===== tb/measurement_period_averager_tb.sv
// Self-checking bench for the measurement period averager
`timescale 1ns/1ps
module measurement_period_averager_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic res_ready = 1'b1;
  logic [mpa_pkg::RATE_W-1:0] rate_sel = 4'h0;
  logic [mpa_pkg::NE-1:0][mpa_pkg::SRC_W-1:0] sync_sel = '1;
  logic samp_valid, samp_ready, samp_last, harm_tick, harm_window, exp_mode, res_valid, hung;
  logic signed [mpa_pkg::NE-1:0][mpa_pkg::SW-1:0] samp_volt, samp_curr;
  mpa_pkg::mpa_result_t res_data, r;
  int n_mismatch = 0;
  int checked = 0;
  logic signed [mpa_pkg::SW-1:0] pat [20] = '{-16'sh64, -16'sh64, 16'sh12c, 16'sh12c, -16'sh64, -16'sh64,
    16'sh12c, 16'sh1f4, -16'sh64, -16'sh64, 16'sh12c, 16'sh12c, -16'sh64, -16'sh64, 16'sh12c, 16'sh12c,
    -16'sh64, -16'sh64, 16'sh12c, 16'sh12c};

  always #5 clk = ~clk;

  mpa_averager u_mpa_averager (.clk(clk), .rstn(rstn), .rate_sel(rate_sel), .sync_sel(sync_sel),
    .samp_valid(samp_valid), .samp_ready(samp_ready), .samp_last(samp_last), .samp_volt(samp_volt),
    .samp_curr(samp_curr), .harm_tick(harm_tick), .harm_window(harm_window), .exp_mode(exp_mode),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));

  mpa_src_model u_mpa_src_model (.clk(clk), .samp_ready(samp_ready), .samp_valid(samp_valid),
    .samp_last(samp_last), .samp_volt(samp_volt), .samp_curr(samp_curr), .harm_tick(harm_tick), .hung(hung));

  task automatic wrap_up();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cfg(input logic [mpa_pkg::RATE_W-1:0] rt, input logic [mpa_pkg::SRC_W-1:0] s0, s1);
    #1;
    rate_sel = rt;
    sync_sel = {s1, s0};
    @(posedge clk);
  endtask

  task automatic send(input int n, input logic signed [mpa_pkg::SW-1:0] v0, i0, v1, i1);
    for (int k = 1; k <= n; k++) u_mpa_src_model.put(v0, i0, v1, i1, k == n, k % 3 == 2);
    u_mpa_src_model.idle();
  endtask

  // Captures the word at the edge where it is popped
  task automatic get();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (res_valid !== 1'b1 && n < 50);
    if (res_valid !== 1'b1 || hung) begin
      n_mismatch++;
      $display("BAD res_valid expected 1 seen %b", res_valid);
      wrap_up();
    end
    r = res_data;
  endtask

  task automatic t_exp();
    cfg(mpa_pkg::RATE_1S, 3'h0, mpa_pkg::SRC_NONE);
    for (int k = 0; k < 4; k++) u_mpa_src_model.put(k == 3 ? 16'sh0c80 : 16'sh0640, -16'sh28,
      k == 3 ? 16'sh0c80 : 16'sh0640, -16'sh28, k == 3, 0);
    u_mpa_src_model.idle();
    get();
    chk("exp_bit", 64'h1, r.exp_mode);
    chk("v0_short", 64'h1, r.elem[0].voltage_mean < 16'sh0320);
    chk("v_same", r.elem[0].voltage_mean, r.elem[1].voltage_mean);
    chk("v0_peak", 64'hc80, r.elem[0].voltage_max_peak);
    chk("v0_crest", 64'h199, r.elem[0].voltage_crest_factor);
    chk("i0_min", -64'sh28, r.elem[0].current_min_peak);
    chk("i0_max", -64'sh28, r.elem[0].current_max_peak);
    chk("e0", -64'sh4e200, r.elem[0].energy);
    chk("q0", -64'sha0, r.elem[0].charge);
    send(300, 16'sh0640, -16'sh28, 16'sh0640, -16'sh28);
    get();
    chk("v0_settled", 64'h1, r.elem[0].voltage_mean inside {16'sh063f, 16'sh0640});
    chk("v_same", r.elem[0].voltage_mean, r.elem[1].voltage_mean);
  endtask

  task automatic t_scan();
    for (int k = 0; k < 9; k++) begin
      cfg(4'(k), 3'h0, 3'h3);
      send(3, 16'sh01f4, 16'sh0014, 16'sh01f4, 16'sh0014);
      get();
      chk("exp_bit", 64'(k >= 2 && k <= 5), r.exp_mode);
      if (k < 2 || k > 5) chk("v1_mean", 64'h1f4, r.elem[1].voltage_mean);
      chk("exp_pin", 64'(k >= 2 && k <= 5), exp_mode);
      chk("v1_crest", 64'h100, r.elem[1].voltage_crest_factor);
      chk("i1_crest", 64'h100, r.elem[1].current_crest_factor);
      chk("e1", 64'h7530, r.elem[1].energy);
      chk("q1", 64'h3c, r.elem[1].charge);
    end
  endtask

  task automatic t_sync();
    for (int j = 0; j < 2; j++) begin
      cfg(j ? mpa_pkg::RATE_5S : mpa_pkg::RATE_50MS, 3'h0, j ? 3'h3 : mpa_pkg::SRC_NONE);
      for (int k = 0; k < 10; k++) u_mpa_src_model.put(pat[10*j+k], 16'sh000a, pat[10*j+k], pat[10*j+k], k == 9, 0);
      u_mpa_src_model.idle();
      get();
      chk("v0_mean", j ? 64'h64 : 64'h7d, r.elem[0].voltage_mean);
      chk("i0_mean", 64'ha, r.elem[0].current_mean);
      chk("v1_mean", j ? 64'h64 : 64'h50, r.elem[1].voltage_mean);
      chk("i1_max", j ? 64'h12c : 64'h1f4, r.elem[1].current_max_peak);
      chk("e0", j ? 64'h36b0 : 64'h1f40, r.elem[0].energy);
      chk("q0", 64'h64, r.elem[0].charge);
      chk("i1_min", -64'sh64, r.elem[1].current_min_peak);
    end
  endtask

  task automatic t_buf();
    #1;
    res_ready = 1'b0;
    rate_sel = mpa_pkg::RATE_100MS;
    sync_sel = {mpa_pkg::SRC_NONE, mpa_pkg::SRC_NONE};
    @(posedge clk);
    for (int v = 1; v <= 3; v++) send(1, 16'(v), 16'sh0001, 16'(v), 16'sh0001);
    repeat (6) @(posedge clk);
    chk("stall_ready", 64'h0, samp_ready);
    chk("held_valid", 64'h1, res_valid);
    #1 res_ready = 1'b1;
    for (int v = 1; v <= 3; v++) begin
      get();
      chk("buf_order", 64'(v), r.elem[0].voltage_mean);
    end
  endtask

  task automatic t_harm();
    u_mpa_src_model.harm(8999);
    chk("harm_open", 64'h1, harm_window);
    u_mpa_src_model.harm(1);
    repeat (2) @(posedge clk);
    #1 chk("harm_shut", 64'h0, harm_window);
    @(posedge clk);
    send(1, 16'sh0005, 16'sh0001, 16'sh0005, 16'sh0001);
    get();
    repeat (2) @(posedge clk);
    #1 chk("harm_reopen", 64'h1, harm_window);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1;
    chk("rst_ready", 64'h0, samp_ready);
    chk("rst_valid", 64'h0, res_valid);
    chk("rst_harm", 64'h1, harm_window);
    chk("rst_exp", 64'h0, exp_mode);
    chk("rst_data", 64'h0, |res_data);
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk);
    t_exp();
    t_scan();
    t_sync();
    t_buf();
    t_harm();
    wrap_up();
  end
endmodule
